// File: hw/lrsdc_pkg.sv
`default_nettype none
package lrsdc_pkg;
    // clock and row timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned ROW_TIME_NS   = 40000;
    localparam int unsigned ROW_CYCLES    = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // panel geometry
    localparam int unsigned COLUMNS       = 96;
    localparam int unsigned ROW_DRIVERS   = 26;
    localparam int unsigned CHAR_DRIVERS  = 24;
    localparam int unsigned ICON_ROW_A    = 24;
    localparam int unsigned ICON_ROW_B    = 25;
    localparam int unsigned GLYPH_W       = 6;
    localparam int unsigned MEM_ROWS      = 5;
    localparam int unsigned MEM_ROW_LEN   = 16;
    localparam int unsigned CHAR_WORDS    = 80;
    localparam int unsigned ICON_WORDS    = 96;
    localparam int unsigned BLINK_BIT     = 4;

    // line count codes
    localparam logic [2:0]  LINES_MIN     = 3'h1;
    localparam logic [2:0]  LINES_MAX     = 3'h3;

    // address map
    localparam logic [11:0] CTRL_OFS      = 12'h000;
    localparam logic [11:0] POWER_OFS     = 12'h004;
    localparam logic [11:0] CURSOR_OFS    = 12'h008;
    localparam logic [11:0] STATUS_OFS    = 12'h00c;
    localparam logic [1:0]  REG_REGION    = 2'h0;
    localparam logic [1:0]  CHAR_REGION   = 2'h1;
    localparam logic [1:0]  ICON_REGION   = 2'h2;

    // control register fields
    localparam int unsigned CTRL_BITS     = 14;
    localparam int unsigned DRIVE_BIT     = 0;
    localparam int unsigned STANDBY_BIT   = 1;
    localparam int unsigned SLEEP_BIT     = 2;
    localparam int unsigned COLREV_BIT    = 3;
    localparam int unsigned ROWREV_BIT    = 4;
    localparam int unsigned LINE_LSB      = 5;
    localparam int unsigned FIRST_LSB     = 8;
    localparam int unsigned FOLLOW_BIT    = 11;
    localparam int unsigned CURSOR_BIT    = 12;
    localparam int unsigned BLINK_EN_BIT  = 13;

    // power register fields
    localparam int unsigned POWER_BITS    = 10;
    localparam int unsigned BOOST_LSB     = 0;
    localparam int unsigned BIAS_LSB      = 2;
    localparam int unsigned CONTRAST_LSB  = 5;

    // status register fields
    localparam int unsigned ROW_LSB       = 0;
    localparam int unsigned ACTIVE_BIT    = 5;
    localparam int unsigned FRAME_LSB     = 8;

    // reset values
    localparam logic [CTRL_BITS-1:0]  CTRL_RESET  = 14'h0020;
    localparam logic [POWER_BITS-1:0] POWER_RESET = 10'h000;

    typedef enum logic [1:0] {
        LRSDC_IDLE = 2'b00,
        LRSDC_CODE = 2'b01,
        LRSDC_TAKE = 2'b11
    } lrsdc_fetch_t;
endpackage : lrsdc_pkg
`default_nettype wire

// File: hw/lrsdc_top.sv
`timescale 1ns/1ps
`default_nettype none
module lrsdc_top #(
    parameter int unsigned COLS       = lrsdc_pkg::COLUMNS,
    parameter int unsigned ROW_CYCLES = lrsdc_pkg::ROW_CYCLES
) (
    // clock and reset
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    // apb slave
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [11:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    // glyph table lookup
    output logic      [7:0]                            glyph_code,
    output logic      [2:0]                            glyph_line,
    input  wire logic [lrsdc_pkg::GLYPH_W-1:0]         glyph_bits,
    // panel drivers
    output logic      [lrsdc_pkg::ROW_DRIVERS-1:0]     row_select,
    output logic      [COLS-1:0]                       col_data,
    output logic                                       drive_active,
    // analog controls
    output logic                                       osc_enable,
    output logic                                       follower_on,
    output logic      [1:0]                            boost_factor,
    output logic      [2:0]                            bias_code,
    output logic      [4:0]                            contrast_step
);
    localparam int unsigned CHARS = COLS / lrsdc_pkg::GLYPH_W;

    typedef struct packed {
        logic                                          ready;
        logic                                          slverr;
        logic [31:0]                                   rdata;
        logic [lrsdc_pkg::CTRL_BITS-1:0]               ctrl;
        logic [lrsdc_pkg::POWER_BITS-1:0]              power;
        logic [6:0]                                    cursor;
        logic [lrsdc_pkg::CHAR_WORDS-1:0][7:0]         char_mem;
        logic [lrsdc_pkg::ICON_WORDS-1:0][1:0]         icon_mem;
        logic [15:0]                                   tick_cnt;
        logic [4:0]                                    scan_row;
        logic [4:0]                                    fetch_row;
        logic [7:0]                                    frame_cnt;
        lrsdc_pkg::lrsdc_fetch_t                       fstate;
        logic [3:0]                                    fetch_col;
        logic [7:0]                                    glyph_code;
        logic [2:0]                                    glyph_line;
        logic                                          cursor_hit;
        logic [1:0][lrsdc_pkg::GLYPH_W-1:0]            fifo_data;
        logic [1:0]                                    fifo_cnt;
        logic [COLS-1:0]                               shreg;
        logic [4:0]                                    shift_cnt;
        logic [COLS-1:0]                               latch;
        logic [lrsdc_pkg::ROW_DRIVERS-1:0]             row_select;
        logic [COLS-1:0]                               col_data;
        logic                                          drive_active;
        logic                                          osc_enable;
        logic                                          follower_on;
    } lrsdc_state_t;

    localparam lrsdc_state_t ST_RESET = '{
        ctrl:       lrsdc_pkg::CTRL_RESET,
        power:      lrsdc_pkg::POWER_RESET,
        fstate:     lrsdc_pkg::LRSDC_IDLE,
        osc_enable: 1'b1,
        default:    '0
    };

    lrsdc_state_t                        st;
    lrsdc_state_t                        next_st;
    logic                                run;
    logic                                drive_ok;
    logic                                row_tick;
    logic                                push;
    logic                                pop;
    logic [lrsdc_pkg::ROW_DRIVERS-1:0]   act_mask;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic line_ok(input logic [2:0] code);
        return (code >= lrsdc_pkg::LINES_MIN) && (code <= lrsdc_pkg::LINES_MAX);
    endfunction : line_ok

    // logical rows per frame: 8 per line plus two icon rows
    function automatic logic [4:0] row_count(input logic [2:0] code);
        return 5'({code[1:0], 3'b000}) + 5'h2;
    endfunction : row_count

    // memory row shown on display line, wrapping after the fifth row
    function automatic logic [2:0] mem_row(input logic [2:0] first, input logic [1:0] line);
        int s;
        s = (int'(first) % lrsdc_pkg::MEM_ROWS + int'(line)) % lrsdc_pkg::MEM_ROWS;
        return 3'(s);
    endfunction : mem_row

    // driver that a logical row lands on
    function automatic logic [lrsdc_pkg::ROW_DRIVERS-1:0] row_bit(input logic [4:0] r,
                                                                 input logic [2:0] code,
                                                                 input logic       rev);
        logic [5:0]                          nchar;
        logic [lrsdc_pkg::ROW_DRIVERS-1:0]   m;
        nchar = {code, 3'b000};
        m     = '0;
        if (!line_ok(code))
            m = '0;
        else if (6'(r) < nchar)
            m[rev ? 5'(lrsdc_pkg::CHAR_DRIVERS - 1) - r : r] = 1'b1;
        else if (6'(r) == nchar)
            m[lrsdc_pkg::ICON_ROW_A] = 1'b1;
        else if (6'(r) == nchar + 6'h1)
            m[lrsdc_pkg::ICON_ROW_B] = 1'b1;
        return m;
    endfunction : row_bit

    function automatic logic [lrsdc_pkg::ROW_DRIVERS-1:0] active_mask(input logic [2:0] code,
                                                                     input logic       rev);
        logic [lrsdc_pkg::ROW_DRIVERS-1:0] m;
        m = '0;
        for (int r = 0; r < lrsdc_pkg::ROW_DRIVERS; r++)
            m = m | row_bit(5'(r), code, rev);
        return m;
    endfunction : active_mask

    function automatic logic [lrsdc_pkg::GLYPH_W-1:0] rev6(input logic [lrsdc_pkg::GLYPH_W-1:0] v);
        logic [lrsdc_pkg::GLYPH_W-1:0] o;
        o = '0;
        for (int k = 0; k < lrsdc_pkg::GLYPH_W; k++)
            o[k] = v[lrsdc_pkg::GLYPH_W - 1 - k];
        return o;
    endfunction : rev6

    function automatic logic addr_ok(input logic [11:0] a);
        logic ok;
        ok = 1'b0;
        unique case (a[11:10])
            lrsdc_pkg::REG_REGION:  ok = (a == lrsdc_pkg::CTRL_OFS) || (a == lrsdc_pkg::POWER_OFS)
                                      || (a == lrsdc_pkg::CURSOR_OFS) || (a == lrsdc_pkg::STATUS_OFS);
            lrsdc_pkg::CHAR_REGION: ok = (a[1:0] == 2'h0) && (int'(a[9:2]) < lrsdc_pkg::CHAR_WORDS);
            lrsdc_pkg::ICON_REGION: ok = (a[1:0] == 2'h0) && (int'(a[9:2]) < lrsdc_pkg::ICON_WORDS);
            default:                ok = 1'b0;
        endcase
        return ok;
    endfunction : addr_ok

    ////////////////////////////////////////////////////////////////////////////////
    assign act_mask = active_mask(st.ctrl[lrsdc_pkg::LINE_LSB +: 3], st.ctrl[lrsdc_pkg::ROWREV_BIT]);

    always_comb
    begin
        logic [2:0]                    lines;
        logic [5:0]                    nchar;
        logic [4:0]                    n_act;
        logic [2:0]                    mrow;
        logic [6:0]                    addr;
        logic [7:0]                    idx;
        logic [1:0]                    cnt;
        logic [lrsdc_pkg::GLYPH_W-1:0] slice;
        logic [lrsdc_pkg::GLYPH_W-1:0] head;
        logic                          blink_phase;
        lines       = st.ctrl[lrsdc_pkg::LINE_LSB +: 3];
        nchar       = {lines, 3'b000};
        n_act       = row_count(lines);
        mrow        = '0;
        addr        = '0;
        idx         = paddr[9:2];
        cnt         = st.fifo_cnt;
        slice       = '0;
        head        = st.fifo_data[0];
        blink_phase = !st.ctrl[lrsdc_pkg::BLINK_EN_BIT] || st.frame_cnt[lrsdc_pkg::BLINK_BIT];
        next_st     = st;
        push        = 1'b0;
        pop         = 1'b0;
        // standby halts the scan as the stopped oscillator would
        run         = !st.ctrl[lrsdc_pkg::STANDBY_BIT] && !st.ctrl[lrsdc_pkg::SLEEP_BIT]
                      && line_ok(lines);
        drive_ok    = run && st.ctrl[lrsdc_pkg::DRIVE_BIT];
        row_tick    = run && (st.tick_cnt == 16'(ROW_CYCLES - 1));

        // bus: answer in the access phase, zero wait states
        next_st.ready  = psel && !penable;
        next_st.slverr = 1'b0;
        next_st.rdata  = '0;
        if (psel && !penable && !pwrite)
        begin
            next_st.slverr = !addr_ok(paddr);
            if (paddr == lrsdc_pkg::CTRL_OFS)
                next_st.rdata = 32'(st.ctrl);
            else if (paddr == lrsdc_pkg::POWER_OFS)
                next_st.rdata = 32'(st.power);
            else if (paddr == lrsdc_pkg::CURSOR_OFS)
                next_st.rdata = 32'(st.cursor);
            else if (paddr == lrsdc_pkg::STATUS_OFS)
            begin
                next_st.rdata[lrsdc_pkg::ROW_LSB +: 5]   = st.scan_row;
                next_st.rdata[lrsdc_pkg::ACTIVE_BIT]     = st.drive_active;
                next_st.rdata[lrsdc_pkg::FRAME_LSB +: 8] = st.frame_cnt;
            end
            else if (addr_ok(paddr) && paddr[11:10] == lrsdc_pkg::CHAR_REGION)
                next_st.rdata = 32'(st.char_mem[idx]);
            else if (addr_ok(paddr) && paddr[11:10] == lrsdc_pkg::ICON_REGION)
                next_st.rdata = 32'(st.icon_mem[idx]);
        end
        else if (psel && !penable)
            next_st.slverr = !addr_ok(paddr);
        if (psel && penable && st.ready && pwrite)
        begin
            if (paddr == lrsdc_pkg::CTRL_OFS)
                next_st.ctrl = pwdata[lrsdc_pkg::CTRL_BITS-1:0];
            else if (paddr == lrsdc_pkg::POWER_OFS)
                next_st.power = pwdata[lrsdc_pkg::POWER_BITS-1:0];
            else if (paddr == lrsdc_pkg::CURSOR_OFS)
                next_st.cursor = pwdata[6:0];
            else if (addr_ok(paddr) && paddr[11:10] == lrsdc_pkg::CHAR_REGION)
                next_st.char_mem[idx] = pwdata[7:0];
            else if (addr_ok(paddr) && paddr[11:10] == lrsdc_pkg::ICON_REGION)
                next_st.icon_mem[idx] = pwdata[1:0];
        end

        // row timer
        if (run)
            next_st.tick_cnt = row_tick ? 16'h0 : st.tick_cnt + 16'h1;

        // display fetch, independent of the bus port
        unique case (st.fstate)
            lrsdc_pkg::LRSDC_IDLE:
                next_st.fstate = lrsdc_pkg::LRSDC_IDLE;
            lrsdc_pkg::LRSDC_CODE:
            begin
                if (6'(st.fetch_row) < nchar)
                begin
                    mrow = mem_row(st.ctrl[lrsdc_pkg::FIRST_LSB +: 3], st.fetch_row[4:3]);
                    addr = 7'(int'(mrow) * lrsdc_pkg::MEM_ROW_LEN + int'(st.fetch_col));
                    next_st.glyph_code = st.char_mem[addr];
                    next_st.glyph_line = st.fetch_row[2:0];
                    next_st.cursor_hit = st.ctrl[lrsdc_pkg::CURSOR_BIT] && (addr == st.cursor);
                end
                else
                    next_st.cursor_hit = 1'b0;
                next_st.fstate = lrsdc_pkg::LRSDC_TAKE;
            end
            lrsdc_pkg::LRSDC_TAKE:
            begin
                if (6'(st.fetch_row) >= nchar)
                begin
                    for (int k = 0; k < lrsdc_pkg::GLYPH_W; k++)
                        slice[k] = st.icon_mem[int'(st.fetch_col) * lrsdc_pkg::GLYPH_W + k]
                                              [6'(st.fetch_row) != nchar];
                end
                else
                    slice = glyph_bits ^ {lrsdc_pkg::GLYPH_W{st.cursor_hit && blink_phase}};
                push = (st.fifo_cnt != 2'h2);
                if (push && st.fetch_col == 4'(CHARS - 1))
                    next_st.fstate = lrsdc_pkg::LRSDC_IDLE;
                else if (push)
                begin
                    next_st.fetch_col = st.fetch_col + 4'h1;
                    next_st.fstate    = lrsdc_pkg::LRSDC_CODE;
                end
            end
        endcase

        // two-entry buffer feeding the column shift register
        pop = (st.fifo_cnt != 2'h0) && (st.shift_cnt < 5'(CHARS)) && !row_tick;
        if (pop)
        begin
            if (st.ctrl[lrsdc_pkg::COLREV_BIT])
                next_st.shreg = {st.shreg[COLS-lrsdc_pkg::GLYPH_W-1:0], rev6(head)};
            else
                next_st.shreg = {head, st.shreg[COLS-1:lrsdc_pkg::GLYPH_W]};
            next_st.fifo_data[0] = st.fifo_data[1];
            next_st.shift_cnt    = st.shift_cnt + 5'h1;
            cnt                  = cnt - 2'h1;
        end
        if (push)
        begin
            next_st.fifo_data[cnt[0]] = slice;
            cnt                       = cnt + 2'h1;
        end
        next_st.fifo_cnt = cnt;

        // row boundary: latch finished pattern, start fetching the following row
        if (row_tick)
        begin
            next_st.latch     = st.shreg;
            next_st.scan_row  = st.fetch_row;
            next_st.fetch_row = (st.fetch_row + 5'h1 >= n_act) ? 5'h0 : st.fetch_row + 5'h1;
            if (st.fetch_row == 5'h0)
                next_st.frame_cnt = st.frame_cnt + 8'h1;
            next_st.shift_cnt = '0;
            next_st.fifo_cnt  = '0;
            next_st.fetch_col = '0;
            next_st.fstate    = lrsdc_pkg::LRSDC_CODE;
        end

        // drivers
        next_st.row_select   = drive_ok ? row_bit(next_st.scan_row, lines,
                                                  st.ctrl[lrsdc_pkg::ROWREV_BIT]) : '0;
        next_st.col_data     = drive_ok ? next_st.latch : '0;
        next_st.drive_active = drive_ok;
        next_st.osc_enable   = !st.ctrl[lrsdc_pkg::STANDBY_BIT];
        next_st.follower_on  = st.ctrl[lrsdc_pkg::FOLLOW_BIT] && drive_ok;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign prdata        = st.rdata;
    assign pready        = st.ready;
    assign pslverr       = st.slverr;
    assign glyph_code    = st.glyph_code;
    assign glyph_line    = st.glyph_line;
    assign row_select    = st.row_select;
    assign col_data      = st.col_data;
    assign drive_active  = st.drive_active;
    assign osc_enable    = st.osc_enable;
    assign follower_on   = st.follower_on;
    assign boost_factor  = st.power[lrsdc_pkg::BOOST_LSB +: 2];
    assign bias_code     = st.power[lrsdc_pkg::BIAS_LSB +: 3];
    assign contrast_step = st.power[lrsdc_pkg::CONTRAST_LSB +: 5];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    blank_drive_a: assert property (
        !drive_ok |=> (row_select == '0) && (col_data == '0) && !drive_active)
        else $error("drivers not at ground while blanked");
    rows_limit_a: assert property (
        1'b1 |=> ((row_select & ~$past(act_mask)) == '0))
        else $error("row outside programmed lines selected");
    row_onehot_a: assert property (
        $onehot0(row_select))
        else $error("more than one row selected");
    latch_hold_a: assert property (
        drive_ok && !row_tick && $past(drive_ok) |=> $stable(col_data))
        else $error("column data changed inside a row");
    latch_load_a: assert property (
        row_tick && drive_ok |=> (col_data == $past(st.shreg)))
        else $error("column data not loaded from shift register");
    standby_osc_a: assert property (
        st.ctrl[lrsdc_pkg::STANDBY_BIT] |=> !osc_enable && !drive_active)
        else $error("oscillator running in standby");
    tick_spacing_a: assert property (
        row_tick |=> !row_tick [*8])
        else $error("row boundaries too close");
    row_complete_a: assert property (
        row_tick && drive_ok && (st.frame_cnt != 8'h0) |-> (st.shift_cnt == 5'(CHARS)))
        else $error("row latched before all columns arrived");
    follower_off_a: assert property (
        !st.ctrl[lrsdc_pkg::FOLLOW_BIT] |=> !follower_on)
        else $error("followers on while switched off");
    apb_ready_a: assert property (
        psel && !penable |=> pready ##1 !pready || (psel && !penable))
        else $error("apb answer not in access phase");
endmodule : lrsdc_top
`default_nettype wire

// File: dv/lrsdc_glyph_model.sv
`timescale 1ns/1ps
`default_nettype none
module lrsdc_glyph_model (
    // lookup request
    input  wire logic [7:0] glyph_code,
    input  wire logic [2:0] glyph_line,
    // table answer, bit0 leftmost pixel
    output logic      [5:0] glyph_bits
);
    assign glyph_bits = glyph_code[5:0] ^ {glyph_line, glyph_line};
endmodule : lrsdc_glyph_model
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        follower_on, osc_enable, drive_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  glyph_code;
    logic [2:0]  glyph_line, bias_code;
    logic [5:0]  glyph_bits;
    logic [25:0] row_select;
    logic [95:0] col_data, e;
    logic [1:0]  boost_factor;
    logic [4:0]  contrast_step;
    int          error_cnt, n_tests;
    lrsdc_top #(.COLS(96), .ROW_CYCLES(64)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .glyph_code, .glyph_line, .glyph_bits,
        .row_select, .col_data, .drive_active, .osc_enable, .follower_on, .boost_factor,
        .bias_code, .contrast_step);
    lrsdc_glyph_model glyph (.glyph_code, .glyph_line, .glyph_bits);
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [95:0] s, input logic [95:0] x);
        n_tests++;
        if (s !== x) $display("mismatch %s expected %h seen %h", nm, x, s);
        if (s !== x) error_cnt++;
    endtask : chk
    // setup, then access held until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge pclk);
        end
        if (n >= 20)
        begin
            error_cnt++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wait_sel(input logic [25:0] v);
        int n;
        n = 0;
        repeat (2)
        begin
            @(negedge pclk);
            while (row_select === v && n < 3000) begin n++; @(negedge pclk); end
            while (row_select !== v && n < 3000) begin n++; @(negedge pclk); end
        end
        if (n >= 3000) begin error_cnt++; stop_test(); end
    endtask : wait_sel
    task collect(input logic [25:0] x, input int cyc);
        logic [25:0] s;
        s = '0;
        repeat (cyc)
        begin
            @(negedge pclk);
            s |= row_select;
        end
        chk("rows used", 96'(s), 96'(x));
    endtask : collect
    // code stored at char address a is a + a/16, glyph line 0 passes it unchanged
    function automatic logic [95:0] pat(input logic rev, input int r);
        logic [7:0] c;
        pat = '0;
        for (int i = 0; i < 16; i++)
            for (int j = 0; j < 6; j++)
            begin
                c = 8'(17 * r + i);
                pat[rev ? 95 - 6 * i - j : 6 * i + j] = c[j];
            end
    endfunction : pat
    ////////////////////////////////////////////////////////////////////////////////
    task test_regs;
        apb(1'b0, lrsdc_pkg::CTRL_OFS, 32'h0);
        chk("ctrl reset", 96'(rd), 96'h20);
        chk("osc reset", 96'(osc_enable), 96'h1);
        apb(1'b1, lrsdc_pkg::POWER_OFS, 32'h3f6);
        apb(1'b0, lrsdc_pkg::POWER_OFS, 32'h0);
        chk("power", 96'(rd), 96'h3f6);
        chk("boost", 96'(boost_factor), 96'h2);
        chk("bias", 96'(bias_code), 96'h5);
        chk("contrast", 96'(contrast_step), 96'h1f);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 96'({er, rd}), 96'h1_0000_0000);
    endtask : test_regs
    task test_scan;
        for (int a = 0; a < 80; a++)
            apb(1'b1, 12'(12'h400 + 4 * a), 32'(a + a / 16));
        apb(1'b1, 12'h800, 32'h1);
        apb(1'b1, 12'h804, 32'h2);
        apb(1'b1, lrsdc_pkg::CTRL_OFS, 32'h821);
        wait_sel(26'h1);
        chk("row0", col_data, pat(0, 0));
        chk("follower", 96'(follower_on), 96'h1);
        collect(26'h30000ff, 700);
        wait_sel(26'h1000000);
        chk("icon a", col_data, 96'h1);
        wait_sel(26'h2000000);
        chk("icon b", col_data, 96'h2);
    endtask : test_scan
    task test_wrap;
        apb(1'b1, lrsdc_pkg::CTRL_OFS, 32'h441);
        wait_sel(26'h100);
        chk("wrap", col_data, pat(0, 0));
        wait_sel(26'h1);
        chk("first line", col_data, pat(0, 4));
        apb(1'b1, lrsdc_pkg::CTRL_OFS, 32'h61);
        collect(26'h3ffffff, 1800);
    endtask : test_wrap
    task test_reverse;
        apb(1'b1, lrsdc_pkg::CTRL_OFS, 32'h39);
        wait_sel(26'h800000);
        chk("reversed", col_data, pat(1, 0));
        collect(26'h3ff0000, 700);
    endtask : test_reverse
    task test_cursor;
        apb(1'b1, lrsdc_pkg::CURSOR_OFS, 32'h5);
        apb(1'b1, lrsdc_pkg::CTRL_OFS, 32'h1021);
        wait_sel(26'h1);
        e = pat(0, 0);
        e[35:30] = ~e[35:30];
        chk("cursor", col_data, e);
    endtask : test_cursor
    // from live drive into one blanking setting
    task blank(input string nm, input logic [31:0] c, input logic osc);
        apb(1'b1, lrsdc_pkg::CTRL_OFS, 32'h821);
        apb(1'b1, lrsdc_pkg::CTRL_OFS, c);
        repeat (3) @(posedge pclk);
        chk(nm, 96'({osc_enable, drive_active}), 96'({osc, 1'b0}));
        chk(nm, 96'({follower_on, row_select}), 96'h0);
        chk(nm, col_data, 96'h0);
    endtask : blank
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, error_cnt, n_tests} = '0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_scan();
        test_wrap();
        test_reverse();
        test_cursor();
        blank("drive off", 32'h820, 1'b1);
        blank("standby", 32'h823, 1'b0);
        blank("sleep", 32'h825, 1'b1);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
